// ===== hw/ppa_port.sv
// parallel port address register, pin assignment and read strobe sequencer
// assumes a same-clock register master and external data pins from another domain
`timescale 1ns/1ps
`default_nettype none
`include "ppa_params.svh"

module ppa_port #(
    parameter bit SMALL_PKG = 1'b0,
    parameter int DATA_W = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] gpio_oe,
    input wire logic [DATA_W-1:0] data_in,
    output logic [15:0] port_address_pads,
    output logic [15:0] port_address_oe,
    output logic top_address_bit,
    output logic chip_select_one,
    output logic read_strobe
);
    localparam logic [2:0] PRE_N = 3'(`PPA_PRE_CLKS - 1); // counts are length minus one
    localparam logic [2:0] LATCH_N = 3'(`PPA_LATCH_CLKS - 1);
    localparam logic [2:0] HOLD_N = 3'(`PPA_HOLD_CLKS - 1);

    logic [15:0] port_destination_address; // address and select
    logic [15:0] port_pin_enable; // pad assignment
    ppa_pkg::ppa_ctrl_s ctrl; // mux and select-pad mode
    logic done; // sticky, read finished
    logic [15:0] read_data; // captured external data
    ppa_pkg::ppa_state_e state; // sequencer state
    ppa_pkg::ppa_state_e next_state;
    logic [2:0] cnt; // cycles left in phase
    logic [2:0] next_cnt;
    logic [DATA_W-1:0] data_meta; // first sync stage, read only by data_sync
    logic [DATA_W-1:0] data_sync; // second sync stage
    ppa_pkg::ppa_strobe_s strb; // strobes of the current state

    // register decode
    wire wr_addr = reg_wr && (reg_addr == `PPA_OFS_ADDR);
    wire wr_pin = reg_wr && (reg_addr == `PPA_OFS_PIN_EN);
    wire wr_ctrl = reg_wr && (reg_addr == `PPA_OFS_CTRL);
    wire wr_stat = reg_wr && (reg_addr == `PPA_OFS_STATUS);
    wire busy = (state != ppa_pkg::ST_IDLE);
    wire start = wr_stat && reg_wdata[`PPA_STAT_START] && !busy;
    wire done_clr = wr_stat && reg_wdata[`PPA_STAT_DONE];
    wire phase_end = (cnt == 3'h0);
    wire read_last = (state == ppa_pkg::ST_READ) && phase_end;
    wire [15:0] status_word = {14'h0000, done, busy};

    // read mux, unmapped offsets answer zero
    wire [15:0] rd_mux =
        (reg_addr == `PPA_OFS_ADDR) ? port_destination_address :
        (reg_addr == `PPA_OFS_PIN_EN) ? port_pin_enable :
        (reg_addr == `PPA_OFS_CTRL) ? {14'h0000, ctrl} :
        (reg_addr == `PPA_OFS_STATUS) ? status_word :
        (reg_addr == `PPA_OFS_RDATA) ? read_data : 16'h0000;

    // strobe decode from the state
    assign strb.latch_hi = (state == ppa_pkg::ST_LATCH_HI);
    assign strb.latch_lo = (state == ppa_pkg::ST_LATCH_LO);
    assign strb.rd = (state == ppa_pkg::ST_READ);

    // address register; writes during an access are dropped so the
    // address cannot move inside a setup or hold window
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            port_destination_address <= `PPA_REG_RESET;
        end else if (ce && wr_addr && !busy) begin
            port_destination_address <= reg_wdata;
        end
    end

    // pin enable, unimplemented bits never store
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            port_pin_enable <= `PPA_REG_RESET;
        end else if (ce && wr_pin) begin
            port_pin_enable <= reg_wdata & `PPA_PIN_EN_MASK;
        end
    end

    // control register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl <= '0;
        end else if (ce && wr_ctrl) begin
            ctrl <= reg_wdata[1:0];
        end
    end

    // done flag, a finishing read beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            done <= 1'b0;
        end else if (ce) begin
            if (read_last) begin
                done <= 1'b1;
            end else if (done_clr) begin
                done <= 1'b0;
            end
        end
    end

    // read data answer one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // external data pins cross in through two flops
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_meta <= '0;
            data_sync <= '0;
        end else if (ce) begin
            data_meta <= data_in;
            data_sync <= data_meta;
        end
    end

    // capture on the last cycle of the read strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            read_data <= 16'h0000;
        end else if (ce && read_last) begin
            read_data <= 16'(data_sync);
        end
    end

    // sequencer next state
    always_comb begin
        next_state = state;
        next_cnt = phase_end ? 3'h0 : cnt - 3'h1;
        case (state)
            ppa_pkg::ST_IDLE: begin
                // address goes out first, latches only in mux mode
                if (start) begin
                    next_state = ppa_pkg::ST_SETUP;
                    next_cnt = PRE_N;
                end
            end
            ppa_pkg::ST_SETUP: begin
                if (phase_end) begin
                    next_state = ctrl.mux ? ppa_pkg::ST_LATCH_HI : ppa_pkg::ST_READ;
                    next_cnt = LATCH_N;
                end
            end
            ppa_pkg::ST_LATCH_HI: begin
                if (phase_end) begin
                    next_state = ppa_pkg::ST_HOLD_HI;
                    next_cnt = HOLD_N;
                end
            end
            ppa_pkg::ST_HOLD_HI: begin
                if (phase_end) begin
                    next_state = ppa_pkg::ST_LATCH_LO;
                    next_cnt = LATCH_N;
                end
            end
            ppa_pkg::ST_LATCH_LO: begin
                if (phase_end) begin
                    next_state = ppa_pkg::ST_HOLD_LO;
                    next_cnt = HOLD_N;
                end
            end
            ppa_pkg::ST_HOLD_LO: begin
                // latch phase over before the read strobe rises
                if (phase_end) begin
                    next_state = ppa_pkg::ST_READ;
                    next_cnt = LATCH_N;
                end
            end
            ppa_pkg::ST_READ: begin
                if (phase_end) begin
                    next_state = ppa_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = ppa_pkg::ST_IDLE;
                next_cnt = 3'h0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ppa_pkg::ST_IDLE;
            cnt <= 3'h0;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // strobe and address-side outputs, same one-cycle delay as the pads
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            read_strobe <= 1'b0;
            top_address_bit <= 1'b0;
            chip_select_one <= 1'b0;
        end else if (ce) begin
            read_strobe <= strb.rd;
            top_address_bit <= port_destination_address[`PPA_BIT_TOP];
            chip_select_one <= port_destination_address[`PPA_BIT_CS];
        end
    end

    // per-pad selection; pads outside the enable register stay general i/o
    logic [15:0] pad_sel;
    logic [15:0] pad_val;
    wire [15:0] addr_bits = {2'b00, port_destination_address[`PPA_LOW_MSB:0]};
    wire addr_en_ok = !SMALL_PKG;

    always_comb begin
        pad_sel = 16'h0000;
        pad_val = addr_bits;
        // address pads ten to two
        pad_sel[`PPA_PAD_ADDR_HI:`PPA_PAD_ADDR_LO] =
            port_pin_enable[`PPA_PAD_ADDR_HI:`PPA_PAD_ADDR_LO] & {9{addr_en_ok}};
        // pads one and zero carry latches in mux mode
        pad_sel[`PPA_PAD_LATCH_HI] = port_pin_enable[`PPA_PAD_LATCH_HI];
        pad_sel[`PPA_PAD_LATCH_LO] = port_pin_enable[`PPA_PAD_LATCH_LO];
        if (ctrl.mux) begin
            pad_val[`PPA_PAD_LATCH_HI] = strb.latch_hi;
            pad_val[`PPA_PAD_LATCH_LO] = strb.latch_lo;
        end
        // pad fourteen: select bit fourteen in select-pad mode, otherwise low
        pad_sel[`PPA_PAD_CS] = port_pin_enable[`PPA_PAD_CS];
        pad_val[`PPA_PAD_CS] = ctrl.cs_pad ? port_destination_address[`PPA_BIT_CS] : 1'b0;
    end

    // one pad cell per pad
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_pad
            ppa_pad_cell u_pad (
                .sys_clk(sys_clk),
                .reset(reset),
                .ce(ce),
                .sel_port(pad_sel[gi]),
                .port_val(pad_val[gi]),
                .gpio_out(gpio_out[gi]),
                .gpio_oe(gpio_oe[gi]),
                .pad_out(port_address_pads[gi]),
                .pad_oe(port_address_oe[gi])
            );
        end
    endgenerate

    // checks, frozen cycles cancel an attempt
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset || !ce);

    latch_lo_width_a: assert property (
        $rose(strb.latch_lo) |-> strb.latch_lo[*2] ##1 !strb.latch_lo)
        else $error("low latch pulse not two cycles");
    latch_hi_width_a: assert property (
        $rose(strb.latch_hi) |-> strb.latch_hi[*2] ##1 !strb.latch_hi)
        else $error("high latch pulse not two cycles");
    // the address must have stood unchanged for the whole setup span
    addr_setup_a: assert property (
        $fell(strb.latch_lo) |-> busy && $past(busy, 3) && $stable(addr_bits)
            && (addr_bits == $past(addr_bits, 3)))
        else $error("address not set up before latch fall");
    addr_hold_a: assert property (
        $fell(strb.latch_hi) |-> ##1 $stable(port_destination_address))
        else $error("address not held after latch fall");
    read_width_a: assert property (
        $rose(strb.rd) |-> strb.rd[*2] ##1 !strb.rd)
        else $error("read strobe not two cycles");
    read_order_a: assert property (
        $rose(strb.rd) && ctrl.mux |-> $past(state) == ppa_pkg::ST_HOLD_LO)
        else $error("read strobe before latch phase ended");
    read_capture_a: assert property (
        $fell(strb.rd) |-> read_data == 16'($past(data_sync)))
        else $error("data not captured at read end");
    pin_mask_a: assert property (
        (port_pin_enable & ~`PPA_PIN_EN_MASK) == 16'h0000)
        else $error("unimplemented enable bit set");
    cs_pad_a: assert property (
        pad_sel[14] && ctrl.cs_pad |=>
            port_address_pads[14] == $past(port_destination_address[14]))
        else $error("select pad wrong");
    cs_out_a: assert property (
        1'b1 |=> chip_select_one == $past(port_destination_address[14]))
        else $error("chip select not following bit");

    mux_read_c: cover property (start && ctrl.mux ##[1:12] read_last);
    plain_read_c: cover property (start && !ctrl.mux ##[1:6] read_last);
    done_race_c: cover property (read_last && done_clr);
endmodule
`default_nettype wire

// ===== hw/ppa_params.svh
// constants for the parallel port address and pin-assignment block
// assumes a single 40 MHz sys_clk and a 16-register-slot word address space
`ifndef PPA_PARAMS_SVH
`define PPA_PARAMS_SVH

// register offsets on the plain register port
`define PPA_OFS_ADDR 4'h0
`define PPA_OFS_PIN_EN 4'h2
`define PPA_OFS_CTRL 4'h4
`define PPA_OFS_STATUS 4'h6
`define PPA_OFS_RDATA 4'h8

// reset value shared by every register
`define PPA_REG_RESET 16'h0000
// implemented bits of the pin-enable register
`define PPA_PIN_EN_MASK 16'h47FF

// address register fields
`define PPA_BIT_TOP 15
`define PPA_BIT_CS 14
`define PPA_LOW_MSB 13

// pad positions
`define PPA_PAD_CS 14
`define PPA_PAD_ADDR_HI 10
`define PPA_PAD_ADDR_LO 2
`define PPA_PAD_LATCH_HI 1
`define PPA_PAD_LATCH_LO 0

// control and status fields
`define PPA_CTRL_MUX 0
`define PPA_CTRL_CSPAD 1
`define PPA_STAT_START 0
`define PPA_STAT_BUSY 0
`define PPA_STAT_DONE 1

// timing: clock period and instruction cycle in ns
`define PPA_CLK_NS 25
`define PPA_TCY_NS 100
`define PPA_TCY_CLKS (`PPA_TCY_NS / `PPA_CLK_NS)
// typical half cycle latch and read pulses
`define PPA_LATCH_CLKS ((`PPA_TCY_CLKS / 2) > 0 ? (`PPA_TCY_CLKS / 2) : 1)
// address setup before latch fall, three quarters of a cycle
`define PPA_SETUP_CLKS (((3 * `PPA_TCY_CLKS) / 4) > 0 ? ((3 * `PPA_TCY_CLKS) / 4) : 1)
// part of the setup spent before the latch rises
`define PPA_PRE_CLKS ((`PPA_SETUP_CLKS - `PPA_LATCH_CLKS) > 0 ? (`PPA_SETUP_CLKS - `PPA_LATCH_CLKS) : 1)
// address hold after latch fall, a quarter cycle
`define PPA_HOLD_CLKS ((`PPA_TCY_CLKS / 4) > 0 ? (`PPA_TCY_CLKS / 4) : 1)

`endif

// ===== hw/ppa_pkg.sv
// types for the parallel port address block
// assumes ppa_params.svh supplies all numeric constants
package ppa_pkg;
    // access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_LATCH_HI,
        ST_HOLD_HI,
        ST_LATCH_LO,
        ST_HOLD_LO,
        ST_READ
    } ppa_state_e;

    // software steering bits
    typedef struct packed {
        logic cs_pad;
        logic mux;
    } ppa_ctrl_s;

    // strobes toward the external device
    typedef struct packed {
        logic latch_hi;
        logic latch_lo;
        logic rd;
    } ppa_strobe_s;
endpackage

// ===== hw/ppa_pad_cell.sv
// one shared pad: chooses between port function and general i/o
// assumes the general port logic sits on the same sys_clk
`timescale 1ns/1ps
`default_nettype none
module ppa_pad_cell (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic sel_port,
    input wire logic port_val,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic pad_out,
    output logic pad_oe
);
    // registered pad drive, one cycle of delay for every pad alike
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end else if (ce) begin
            // port function always drives, general i/o follows its own enable
            pad_out <= sel_port ? port_val : gpio_out;
            pad_oe <= sel_port ? 1'b1 : gpio_oe;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/ppa_far_model.sv
// behavioural model of the external parallel memory behind the port
// assumes the port's chip select and read strobe on the same sys_clk
`timescale 1ns/1ps
`default_nettype none
module ppa_far_model #(
    parameter int DATA_W = 8,
    parameter logic [7:0] DATA_VAL = 8'h3C
) (
    input wire logic sys_clk,
    input wire logic chip_select_one,
    input wire logic read_strobe,
    output logic [DATA_W-1:0] data_in
);
    // selected device presents its word; a released bus toggles so that
    // a capture outside the access cannot match by luck; one process owns the bus
    initial begin
        data_in = '0;
        forever begin
            @(posedge sys_clk);
            if (chip_select_one || read_strobe) begin
                data_in <= DATA_W'(DATA_VAL);
            end else begin
                data_in <= ~data_in;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_ppa_port.sv
// self-checking bench for the parallel port address block
// assumes ppa_port at default parameters and the far model beside it
`timescale 1ns/1ps
`default_nettype none
`include "ppa_params.svh"
module tb_ppa_port;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] gpio_out = 16'h0000; // general i/o value, driven by the stimulus only
    logic [15:0] gpio_oe = 16'h0000;
    logic [15:0] reg_rdata, port_address_pads, port_address_oe;
    logic [7:0] data_in;
    logic top_address_bit, chip_select_one, read_strobe;
    logic rd_q = 1'b0; // read issued on the previous edge
    logic mux_on = 1'b0; // gates the strobe width monitor
    logic [15:0] exp_q[$]; // expected read data, oldest first
    int err_count = 0;
    int checked = 0;
    int cnt[3] = '{0, 0, 0}; // running high-time of the three strobes
    logic [31:0] seed = 32'd98951;
    logic [15:0] a0, a1, m;
    // free-running 25 ns clock
    always #12.5 sys_clk = ~sys_clk;
    ppa_port u_ppa_port (.sys_clk(sys_clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .data_in(data_in),
        .port_address_pads(port_address_pads), .port_address_oe(port_address_oe),
        .top_address_bit(top_address_bit), .chip_select_one(chip_select_one),
        .read_strobe(read_strobe));
    ppa_far_model u_ppa_far_model (.sys_clk(sys_clk), .chip_select_one(chip_select_one),
        .read_strobe(read_strobe), .data_in(data_in));
    // galois shift register for stimulus values
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'hA300_0001 : 32'h0000_0000);
    endfunction
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (e !== g) begin
            $display("[ERR] %s expected %h seen %h", name, e, g);
            err_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // the expectation is noted before the strobe goes out
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic rnd();
        seed = lfsr_next(seed);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk) rd_q <= reg_rd;
    always @(negedge sys_clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                chk("unexpected read", 16'h0000, 16'hFFFF);
            end else begin
                chk("reg_rdata", exp_q.pop_front(), reg_rdata);
            end
        end
    end
    // strobe width monitor: latch high, latch low, read strobe
    always @(negedge sys_clk) begin
        logic [2:0] s;
        s = {port_address_pads[1], port_address_pads[0], read_strobe};
        for (int i = 0; i < 3; i++) begin
            if (mux_on && s[i] === 1'b1) begin
                cnt[i]++;
            end else if (cnt[i] != 0) begin
                chk("strobe width", 16'(`PPA_LATCH_CLKS), 16'(cnt[i]));
                cnt[i] = 0;
            end
        end
    end
    // hang guard, well beyond the planned run
    initial begin
        #(25 * 20000);
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`PPA_OFS_ADDR, 16'h0000);
        rd(`PPA_OFS_PIN_EN, 16'h0000);
        rd(4'hE, 16'h0000);
        // unimplemented enable bits never store
        wr(`PPA_OFS_PIN_EN, 16'hFFFF);
        rd(`PPA_OFS_PIN_EN, 16'h47FF);
        wr(`PPA_OFS_CTRL, 16'h0002);
        // random addresses with and without pad enables
        for (int k = 0; k < 6; k++) begin
            rnd();
            a0 = seed[15:0];
            rnd();
            @(posedge sys_clk);
            gpio_out <= seed[15:0];
            gpio_oe <= seed[31:16];
            m = k[0] ? 16'h0000 : 16'h47FF;
            wr(`PPA_OFS_PIN_EN, m);
            wr(`PPA_OFS_ADDR, a0);
            rd(`PPA_OFS_ADDR, a0);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk("top_address_bit", 16'(a0[15]), 16'(top_address_bit));
            chk("chip_select_one", 16'(a0[14]), 16'(chip_select_one));
            chk("pads", (gpio_out & ~m) | (a0 & m), port_address_pads);
            chk("pad oe", gpio_oe | m, port_address_oe);
            // a write while the clock enable is low must leave no trace
            @(posedge sys_clk);
            ce <= 1'b0;
            wr(`PPA_OFS_ADDR, ~a0);
            @(posedge sys_clk);
            ce <= 1'b1;
            rd(`PPA_OFS_ADDR, a0);
        end
        // multiplexed read with a refused address write in flight
        wr(`PPA_OFS_PIN_EN, 16'h47FF);
        wr(`PPA_OFS_CTRL, 16'h0003);
        a1 = 16'h4155;
        wr(`PPA_OFS_ADDR, a1);
        mux_on <= 1'b1;
        wr(`PPA_OFS_STATUS, 16'h0001);
        rd(`PPA_OFS_STATUS, 16'h0001);
        wr(`PPA_OFS_ADDR, 16'h0AAA);
        @(negedge sys_clk);
        chk("latch address", a1 & 16'h07FC, port_address_pads & 16'h07FC);
        repeat (12) @(posedge sys_clk);
        mux_on <= 1'b0;
        rd(`PPA_OFS_STATUS, 16'h0002);
        rd(`PPA_OFS_RDATA, 16'h003C);
        rd(`PPA_OFS_ADDR, a1);
        wr(`PPA_OFS_STATUS, 16'h0002);
        rd(`PPA_OFS_STATUS, 16'h0000);
        repeat (3) @(posedge sys_clk);
        chk("queue empty", 16'h0000, 16'(exp_q.size()));
        report_and_stop();
    end
endmodule
`default_nettype wire
